// ===== include/cdr_cfg_map.vh
// register offsets, field positions and reset values of the loop configuration bank
`ifndef CDR_CFG_MAP_VH
`define CDR_CFG_MAP_VH

// ==========================================
// register offsets
`define OFS_REF_LOCK_SETUP 8'h0F
`define OFS_LOOP_EDGE_BW 8'h10
`define OFS_SLEW_ADAPT_THR 8'h13
`define OFS_SAMPLE_PHASE 8'h14
`define OFS_DECISION_THR 8'h15

// ==========================================
// writable bit masks, reserved bits read zero
`define MASK_REF_LOCK_SETUP 8'h7F
`define MASK_LOOP_EDGE_BW 8'h1F
`define MASK_SLEW_ADAPT_THR 8'h07
`define MASK_SAMPLE_PHASE 8'h0F
`define MASK_DECISION_THR 8'hFF

// ==========================================
// reset values
`define RST_REF_LOCK_SETUP 8'h00
`define RST_LOOP_EDGE_BW 8'h04
`define RST_SLEW_ADAPT_THR 8'h00
`define RST_SAMPLE_PHASE 8'h00
`define RST_DECISION_THR 8'h00

// ==========================================
// field positions
`define BIT_LOCK_LOSS_SRC 6
`define BIT_BAND_HI 5
`define BIT_BAND_LO 4
`define BIT_RATIO_HI 3
`define BIT_EDGE_HI 4
`define BIT_EDGE_LO 3
`define BIT_BW_HI 2
`define BIT_ADAPT_THR 2
`define BIT_SLEW_HI 1
`define BIT_THR_EXT 7
`define BIT_THR_HI 6

// ==========================================
// edge select codes and the largest rate ratio code
`define EDGE_BOTH_A 2'b00
`define EDGE_RISE 2'b01
`define EDGE_FALL 2'b10
`define RATIO_MAX 4'hA

`endif

// ===== logic/cfg_reg_slot.v
// one configuration register: masked write, reset value, read-back
`timescale 1ns/1ns
`default_nettype none
module cfg_reg_slot #(
    parameter [7:0] OFFSET = 8'h00,
    parameter [7:0] MASK = 8'hFF,
    parameter [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // register access
    input wire wr_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    // stored value
    output reg [7:0] value_o
);
    // reserved bits are never stored, so they always read as zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= RESET_VAL;
        end else if (wr_i && addr_i == OFFSET) begin
            value_o <= wdata_i & MASK;
        end
    end
endmodule
`default_nettype wire

// ===== logic/cdr_loop_slice_config_regs.v
// loop and slice configuration register bank with decoded analog controls
`timescale 1ns/1ns
`default_nettype none
`include "cdr_cfg_map.vh"
module cdr_loop_slice_config_regs (
    // clock and reset
    input wire mclk_i,
    input wire resetn_i,
    // register port from the serial interface engine (same clock)
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_hit_o,
    // loop state from the analog side (asynchronous)
    input wire reference_locked_operation_i,
    input wire ref_clock_mismatch_i,
    input wire data_mismatch_i,
    input wire high_rate_i,
    // lock loss and reference controls
    output reg lock_loss_o,
    output reg lock_loss_source_select_o,
    output reg [1:0] reference_band_o,
    output reg [3:0] rate_ratio_code_o,
    output reg rate_ratio_valid_o,
    // phase detector and loop bandwidth
    output reg pd_rise_en_o,
    output reg pd_fall_en_o,
    output reg [2:0] loop_bandwidth_scale_o,
    // delay-locked loop and threshold
    output reg [1:0] dll_slew_o,
    output reg adaptive_threshold_o,
    output reg [6:0] manual_threshold_o,
    output reg threshold_offset_en_o,
    output reg threshold_extended_o,
    // sample phase
    output reg [3:0] sample_phase_o,
    output reg sample_phase_active_o
);
    // ==========================================
    // reset release
    reg rst_meta_r;
    reg rst_sync_r;
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================
    // register slots
    wire [7:0] ref_lock_setup;
    wire [7:0] loop_edge_bandwidth;
    wire [7:0] slew_adaptive_threshold;
    wire [7:0] sample_phase_adjust;
    wire [7:0] decision_threshold;

    cfg_reg_slot #(
        .OFFSET(`OFS_REF_LOCK_SETUP),
        .MASK(`MASK_REF_LOCK_SETUP),
        .RESET_VAL(`RST_REF_LOCK_SETUP)
    ) u_ref_lock_setup (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_r),
        .wr_i(reg_wr_i),
        .addr_i(reg_addr_i),
        .wdata_i(reg_wdata_i),
        .value_o(ref_lock_setup)
    );
    cfg_reg_slot #(
        .OFFSET(`OFS_LOOP_EDGE_BW),
        .MASK(`MASK_LOOP_EDGE_BW),
        .RESET_VAL(`RST_LOOP_EDGE_BW)
    ) u_loop_edge_bandwidth (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_r),
        .wr_i(reg_wr_i),
        .addr_i(reg_addr_i),
        .wdata_i(reg_wdata_i),
        .value_o(loop_edge_bandwidth)
    );
    cfg_reg_slot #(
        .OFFSET(`OFS_SLEW_ADAPT_THR),
        .MASK(`MASK_SLEW_ADAPT_THR),
        .RESET_VAL(`RST_SLEW_ADAPT_THR)
    ) u_slew_adaptive_threshold (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_r),
        .wr_i(reg_wr_i),
        .addr_i(reg_addr_i),
        .wdata_i(reg_wdata_i),
        .value_o(slew_adaptive_threshold)
    );
    cfg_reg_slot #(
        .OFFSET(`OFS_SAMPLE_PHASE),
        .MASK(`MASK_SAMPLE_PHASE),
        .RESET_VAL(`RST_SAMPLE_PHASE)
    ) u_sample_phase_adjust (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_r),
        .wr_i(reg_wr_i),
        .addr_i(reg_addr_i),
        .wdata_i(reg_wdata_i),
        .value_o(sample_phase_adjust)
    );
    cfg_reg_slot #(
        .OFFSET(`OFS_DECISION_THR),
        .MASK(`MASK_DECISION_THR),
        .RESET_VAL(`RST_DECISION_THR)
    ) u_decision_threshold (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_r),
        .wr_i(reg_wr_i),
        .addr_i(reg_addr_i),
        .wdata_i(reg_wdata_i),
        .value_o(decision_threshold)
    );

    // ==========================================
    // read decode, registered; unmapped offsets answer zero with no hit
    reg [7:0] rdata_nxt;
    reg hit_nxt;
    always @* begin
        hit_nxt = 1'b1;
        if (reg_addr_i == `OFS_REF_LOCK_SETUP) begin
            rdata_nxt = ref_lock_setup;
        end else if (reg_addr_i == `OFS_LOOP_EDGE_BW) begin
            rdata_nxt = loop_edge_bandwidth;
        end else if (reg_addr_i == `OFS_SLEW_ADAPT_THR) begin
            rdata_nxt = slew_adaptive_threshold;
        end else if (reg_addr_i == `OFS_SAMPLE_PHASE) begin
            rdata_nxt = sample_phase_adjust;
        end else if (reg_addr_i == `OFS_DECISION_THR) begin
            rdata_nxt = decision_threshold;
        end else begin
            rdata_nxt = 8'h00;
            hit_nxt = 1'b0;
        end
    end

    // read data holds until the next read so a slow serial engine can shift it out
    always @(posedge mclk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reg_rdata_o <= 8'h00;
            reg_hit_o <= 1'b0;
        end else if (reg_rd_i || reg_wr_i) begin
            reg_rdata_o <= reg_rd_i ? rdata_nxt : reg_rdata_o;
            reg_hit_o <= hit_nxt;
        end
    end

    // ==========================================
    // pin synchronisers: three stages, a change counts when stages two and three agree
    wire [3:0] clean_in;
    wire [3:0] raw_in;
    assign raw_in = {high_rate_i, data_mismatch_i, ref_clock_mismatch_i, reference_locked_operation_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            // each pin owns its chain, so every flop has a single driving process
            reg [2:0] stage_r;
            reg agree_r;
            always @(posedge mclk_i or negedge rst_sync_r) begin
                if (!rst_sync_r) begin
                    stage_r <= 3'b000;
                    agree_r <= 1'b0;
                end else begin
                    stage_r <= {stage_r[1:0], raw_in[gi]};
                    // a lone disagreement is a settling bit, not yet a change
                    if (stage_r[1] == stage_r[2]) begin
                        agree_r <= stage_r[2];
                    end
                end
            end
            assign clean_in[gi] = agree_r;
        end
    endgenerate

    // ==========================================
    // decoded controls
    // edges the phase detector may use for a given edge-select code
    function [1:0] edge_enables;
        input [1:0] code;
        begin
            case (code)
                `EDGE_RISE: edge_enables = 2'b10;
                `EDGE_FALL: edge_enables = 2'b01;
                default: edge_enables = 2'b11;
            endcase
        end
    endfunction

    wire [1:0] edge_en;
    wire src_data;
    assign edge_en = edge_enables(loop_edge_bandwidth[`BIT_EDGE_HI:`BIT_EDGE_LO]);
    assign src_data = ref_lock_setup[`BIT_LOCK_LOSS_SRC];

    // all control outputs are flopped copies so the analog side sees glitch-free levels
    always @(posedge mclk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            lock_loss_o <= 1'b0;
            lock_loss_source_select_o <= 1'b0;
            reference_band_o <= 2'b00;
            rate_ratio_code_o <= 4'h0;
            rate_ratio_valid_o <= 1'b1;
            pd_rise_en_o <= 1'b1;
            pd_fall_en_o <= 1'b1;
            loop_bandwidth_scale_o <= 3'h4;
            dll_slew_o <= 2'b00;
            adaptive_threshold_o <= 1'b0;
            manual_threshold_o <= 7'h00;
            threshold_offset_en_o <= 1'b0;
            threshold_extended_o <= 1'b0;
            sample_phase_o <= 4'h0;
            sample_phase_active_o <= 1'b0;
        end else begin
            // lock loss only judged while tracking in reference-locked operation
            lock_loss_o <= clean_in[0] & (src_data ? clean_in[2] : clean_in[1]);
            lock_loss_source_select_o <= src_data;
            reference_band_o <= ref_lock_setup[`BIT_BAND_HI:`BIT_BAND_LO];
            rate_ratio_code_o <= ref_lock_setup[`BIT_RATIO_HI:0];
            // codes above the largest ratio are flagged rather than silently used
            rate_ratio_valid_o <= (ref_lock_setup[`BIT_RATIO_HI:0] <= `RATIO_MAX);
            pd_rise_en_o <= edge_en[1];
            pd_fall_en_o <= edge_en[0];
            loop_bandwidth_scale_o <= loop_edge_bandwidth[`BIT_BW_HI:0];
            dll_slew_o <= slew_adaptive_threshold[`BIT_SLEW_HI:0];
            adaptive_threshold_o <= slew_adaptive_threshold[`BIT_ADAPT_THR];
            manual_threshold_o <= decision_threshold[`BIT_THR_HI:0];
            threshold_offset_en_o <= |decision_threshold[`BIT_THR_HI:0];
            threshold_extended_o <= decision_threshold[`BIT_THR_EXT];
            // phase shift is held at zero below the high-rate boundary
            sample_phase_o <= clean_in[3] ? sample_phase_adjust[3:0] : 4'h0;
            sample_phase_active_o <= clean_in[3];
        end
    end
endmodule
`default_nettype wire

// ===== testbench/cdr_cfg_checker_sva.sv
// assertion checker for the loop configuration bank
`timescale 1ns/1ns
`default_nettype none
module cdr_cfg_checker (
    // clock, reset and register port
    input wire mclk_i,
    input wire resetn_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_hit_o,
    // loop state and decoded controls
    input wire reference_locked_operation_i,
    input wire ref_clock_mismatch_i,
    input wire data_mismatch_i,
    input wire high_rate_i,
    input wire lock_loss_o,
    input wire lock_loss_source_select_o,
    input wire [1:0] reference_band_o,
    input wire [3:0] rate_ratio_code_o,
    input wire pd_rise_en_o,
    input wire pd_fall_en_o,
    input wire [2:0] loop_bandwidth_scale_o,
    input wire [1:0] dll_slew_o,
    input wire adaptive_threshold_o,
    input wire [6:0] manual_threshold_o,
    input wire threshold_offset_en_o,
    input wire threshold_extended_o,
    input wire [3:0] sample_phase_o,
    input wire rate_ratio_valid_o,
    input wire sample_phase_active_o
);
    // ==== helpers: a lone write to one register, selected mismatch
    wire w0f = reg_wr_i && reg_addr_i == 8'h0f;
    wire w10 = reg_wr_i && reg_addr_i == 8'h10;
    wire w13 = reg_wr_i && reg_addr_i == 8'h13;
    wire w15 = reg_wr_i && reg_addr_i == 8'h15;
    wire mapped = reg_addr_i inside {8'h0f, 8'h10, 8'h13, 8'h14, 8'h15};
    wire sel_mis = reference_locked_operation_i &&
        (lock_loss_source_select_o ? data_mismatch_i : ref_clock_mismatch_i);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // decodes land two edges after the store; a repeat write would move them
    ref_setup_a: assert property (w0f ##1 !w0f |=>
        {lock_loss_source_select_o, reference_band_o, rate_ratio_code_o} == $past(reg_wdata_i[6:0], 2)) else $error("setup");
    edge_sel_a: assert property (w10 ##1 !w10 |=>
        pd_rise_en_o == ($past(reg_wdata_i[4:3], 2) != 2'b10) && pd_fall_en_o == ($past(reg_wdata_i[4:3], 2) != 2'b01))
        else $error("edge select");
    bw_scale_a: assert property (w10 ##1 !w10 |=>
        loop_bandwidth_scale_o == $past(reg_wdata_i[2:0], 2)) else $error("bandwidth");
    slew_adapt_a: assert property (w13 ##1 !w13 |=>
        {adaptive_threshold_o, dll_slew_o} == $past(reg_wdata_i[2:0], 2)) else $error("slew");
    thr_word_a: assert property (w15 ##1 !w15 |=>
        {threshold_extended_o, manual_threshold_o, threshold_offset_en_o} ==
        {$past(reg_wdata_i, 2), |$past(reg_wdata_i[6:0], 2)}) else $error("threshold");
    unmapped_rd_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00 && !reg_hit_o)
        else $error("unmapped");
    reserved_rd_a: assert property (reg_rd_i && reg_addr_i == 8'h14 |=> reg_hit_o && reg_rdata_o[7:4] == 4'h0)
        else $error("reserved");
    // eight samples cover the synchroniser depth plus the agree flop
    lock_set_a: assert property ((sel_mis && $stable(lock_loss_source_select_o)) [*8] |-> lock_loss_o)
        else $error("lock loss missing");
    lock_clear_a: assert property ((!sel_mis && $stable(lock_loss_source_select_o)) [*8] |-> !lock_loss_o)
        else $error("lock loss spurious");
    phase_off_a: assert property (!high_rate_i [*8] |-> sample_phase_o == 4'h0 && !sample_phase_active_o)
        else $error("phase");
    phase_on_a: assert property (high_rate_i [*8] |-> sample_phase_active_o)
        else $error("phase active");
    ratio_valid_a: assert property (w0f ##1 !w0f |=>
        rate_ratio_valid_o == ($past(reg_wdata_i[3:0], 2) <= 4'ha)) else $error("ratio flag");
    c_edge: cover property (w10);
    c_unmapped: cover property (reg_rd_i && !mapped);
    c_lock: cover property (lock_loss_o);
endmodule
`default_nettype wire

// ===== testbench/cdr_cfg_host_model.sv
// host model driving the byte-wide register port
`timescale 1ns/1ns
`default_nettype none
module cdr_cfg_host_model (
    // clock
    input wire logic mclk_i,
    // register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0_0000;
    // one access per call; released lines show inverted junk, not the old value
    task automatic access(input logic w, r, input logic [7:0] a, d, m);
        @(negedge mclk_i);
        {reg_wr_o, reg_rd_o, reg_addr_o} = {w, r, a};
        reg_wdata_o = d & m;
        @(negedge mclk_i);
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ===== testbench/cdr_loop_slice_config_regs_tb_top.sv
// self-checking bench for the loop configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "cdr_cfg_map.vh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin num_errors++; $display("unexpected %0t %s", $time, m); end end
module cdr_loop_slice_config_regs_tb_top;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic lock_op = 1'b0, ref_mis = 1'b0, dat_mis = 1'b0, fast = 1'b0;
    wire wr, rd, hit, lock_loss, rise, fall;
    wire [7:0] addr, wdata, rdata;
    wire [3:0] phase;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [8:0] exp_q[$];
    logic [7:0] ofs [5] = '{8'h0f, 8'h10, 8'h13, 8'h14, 8'h15};
    logic [7:0] msk [5] = '{`MASK_REF_LOCK_SETUP, `MASK_LOOP_EDGE_BW, `MASK_SLEW_ADAPT_THR, `MASK_SAMPLE_PHASE,
        `MASK_DECISION_THR};
    logic [7:0] rst [5] = '{`RST_REF_LOCK_SETUP, `RST_LOOP_EDGE_BW, `RST_SLEW_ADAPT_THR, `RST_SAMPLE_PHASE,
        `RST_DECISION_THR};
    logic [7:0] shadow [5];
    logic [31:0] seed = 32'h0001_22d4;
    cdr_cfg_host_model cdr_cfg_host_model_inst (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    cdr_loop_slice_config_regs cdr_loop_slice_config_regs_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
        .reference_locked_operation_i(lock_op), .ref_clock_mismatch_i(ref_mis), .data_mismatch_i(dat_mis),
        .high_rate_i(fast), .lock_loss_o(lock_loss), .lock_loss_source_select_o(), .reference_band_o(),
        .rate_ratio_code_o(), .rate_ratio_valid_o(), .pd_rise_en_o(rise), .pd_fall_en_o(fall),
        .loop_bandwidth_scale_o(), .dll_slew_o(), .adaptive_threshold_o(), .manual_threshold_o(),
        .threshold_offset_en_o(), .threshold_extended_o(), .sample_phase_o(phase), .sample_phase_active_o());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // write and note the stored value, reserved bits dropped
    task automatic put(input logic [7:0] a, d, m);
        for (int i = 0; i < 5; i++) if (ofs[i] == a) shadow[i] = d & m & msk[i];
        cdr_cfg_host_model_inst.access(1'b1, 1'b0, a, d, m);
    endtask
    // read, optionally with a write in the same cycle (old value expected)
    task automatic get(input logic [7:0] a, input logic w);
        logic [8:0] e;
        e = 9'h000;
        for (int i = 0; i < 5; i++) if (ofs[i] == a) e = {1'b1, shadow[i]};
        exp_q.push_back(e);
        cdr_cfg_host_model_inst.access(w, 1'b1, a, 8'h5a, 8'hff);
    endtask
    always #5 mclk_i = ~mclk_i;
    // watchdog and read monitor
    always @(posedge mclk_i) begin
        if (rd) begin
            #1;
            `CHK({hit, rdata}, exp_q.pop_front(), "read")
        end
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        shadow = rst;
        repeat (5) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        for (int i = 0; i < 5; i++) get(ofs[i], 1'b0);
        put(8'h11, 8'hff, 8'hff);
        get(8'h11, 1'b0);
        put(8'h15, 8'h80, 8'hff);
        get(8'h15, 1'b0);
        // band 01 with ratio 0010 keeps data and reference rates in step
        put(8'h0f, 8'h12, 8'hff);
        get(8'h0f, 1'b0);
        get(8'h13, 1'b1);
        shadow[2] = 8'h5a & msk[2];
        get(8'h13, 1'b0);
        // every edge code; decodes settle two edges after the store
        for (int c = 0; c < 4; c++) begin
            put(8'h10, {3'h0, c[1:0], 3'h4}, 8'hff);
            repeat (2) @(negedge mclk_i);
            `CHK({rise, fall}, {c != 2, c != 1}, "edge")
        end
        // random fields, reserved bits sometimes set on purpose
        repeat (40) begin
            seed = lfsr(seed);
            put(ofs[seed[2:0] % 5], seed[15:8], seed[16] ? 8'hff : msk[seed[2:0] % 5]);
            get(ofs[seed[2:0] % 5], 1'b0);
        end
        put(8'h14, 8'h0b, 8'hff);
        fast = 1'b1;
        repeat (8) @(negedge mclk_i);
        `CHK(phase, shadow[3][3:0], "phase")
        fast = 1'b0;
        repeat (8) @(negedge mclk_i);
        `CHK(phase, 4'h0, "phase off")
        // all source, lock and mismatch combinations
        for (int k = 0; k < 16; k++) begin
            put(8'h0f, {1'b0, k[3], 6'h00}, 8'hff);
            {lock_op, ref_mis, dat_mis} = k[2:0];
            repeat (8) @(negedge mclk_i);
            `CHK(lock_loss, k[2] & (k[3] ? k[0] : k[1]), "lock loss")
        end
        lock_op = 1'b0;
        resetn_i = 1'b0;
        @(negedge mclk_i);
        resetn_i = 1'b1;
        shadow = rst;
        repeat (3) @(negedge mclk_i);
        for (int i = 0; i < 5; i++) get(ofs[i], 1'b0);
        repeat (2) @(negedge mclk_i);
        report_and_stop();
    end
endmodule
bind cdr_loop_slice_config_regs cdr_cfg_checker cdr_cfg_checker_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .reference_locked_operation_i(reference_locked_operation_i),
    .ref_clock_mismatch_i(ref_clock_mismatch_i), .data_mismatch_i(data_mismatch_i),
    .high_rate_i(high_rate_i), .lock_loss_o(lock_loss_o),
    .lock_loss_source_select_o(lock_loss_source_select_o), .reference_band_o(reference_band_o),
    .rate_ratio_code_o(rate_ratio_code_o), .pd_rise_en_o(pd_rise_en_o), .pd_fall_en_o(pd_fall_en_o),
    .loop_bandwidth_scale_o(loop_bandwidth_scale_o), .dll_slew_o(dll_slew_o),
    .adaptive_threshold_o(adaptive_threshold_o), .manual_threshold_o(manual_threshold_o),
    .threshold_offset_en_o(threshold_offset_en_o), .threshold_extended_o(threshold_extended_o),
    .sample_phase_o(sample_phase_o), .rate_ratio_valid_o(rate_ratio_valid_o),
    .sample_phase_active_o(sample_phase_active_o));
`default_nettype wire
